// ==== rtl/spcc_pkg.sv ====
// ----------------------------------------------------------------
// Shared constants and carriers of the card control block
// ----------------------------------------------------------------
package spcc_pkg;

  // ----------------------------------------------------------------
  // Card address map
  // ----------------------------------------------------------------
  localparam logic [31:0] CSR_BASE = 32'h0001_0000;
  localparam logic [31:0] CSR_LAST = 32'h0001_004B;
  localparam logic [31:0] FLUSH_ALL_ADDR = 32'h0001_0044;
  localparam logic [31:0] FLUSH_DATA_ADDR = 32'h0001_0048;
  localparam logic [31:0] ID_ADDR = 32'h0001_4000;

  // ----------------------------------------------------------------
  // Control/status bit positions
  // ----------------------------------------------------------------
  localparam int BIT_RESV15 = 15;
  localparam int BIT_CACHE_OFF = 14;
  localparam int BIT_LOCAL_IRQ = 13;
  localparam int BIT_RESV12 = 12;
  localparam int BIT_MISALIGN = 11;
  localparam int BIT_BUS_ERR = 3;
  localparam int BIT_HOST_IRQ = 2;
  localparam int BIT_HALT = 1;
  localparam int BIT_RESET = 0;

  // Bits that exist; every other bit reads zero and ignores writes
  localparam logic [15:0] CSR_IMPL_MASK = 16'h680F;
  // Cache off and halt set at power-up, the rest clear
  localparam logic [15:0] CSR_RESET = 16'h4002;

  // ----------------------------------------------------------------
  // Identification/vector register
  // ----------------------------------------------------------------
  localparam logic [7:0] ID_HIGH_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Register port carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sel;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } spcc_bus_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } spcc_bus_rsp_t;

endpackage

// ==== rtl/spcc_sync.sv ====
`timescale 1ns/1ns
// Three-stage input synchroniser; output follows once stages two and three agree
module spcc_sync #(
  parameter int WIDTH = 2
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Asynchronous levels in, filtered levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Only the second and third stages are compared; the first may be metastable
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        out_q[i] <= 1'b0;
      end else if (ce && (s2_q[i] == s3_q[i])) begin
        out_q[i] <= s3_q[i];
      end
    end
  end

  assign sync_out = out_q;

endmodule // spcc_sync

// ==== rtl/spcc_ctrl.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - Control/status is 16 bits, read as a 32-bit word, upper half zero.
// - A write changes only the one bit its address selects.
// - Bits 15 and 12 read zero and ignore writes.
// - Bit 14 disables the cache; software sets and clears; power-up sets it.
// - Access to one flush address clears whole cache, other only data part.
// - Bit 13 requests level 15 interrupt at the card processor.
// - Misaligned access fault sets bit 11; software clears it.
// - Bits 4 to 10 always read zero.
// - Bus fault during main memory access sets bit 3; software clears it.
// - Such a bus fault also raises a memory exception to the card processor.
// - Bit 2 sends level 15 interrupt to the host; power-up clears it.
// - Card reset sets bit 1; processor idles until software clears it.
// - Software sets bit 1 to halt synchronously; clearing resumes where stopped.
// - Writing bit 0 resets the card; host bus reset clears it.
// - Identity register holds identity low byte, later an 8-bit vector.
// - Decode control block 0x10000-0x1004B and identity at 0x14000.
module spcc_ctrl #(
  // Low byte of the card identity; value is arbitrary
  parameter logic [7:0] ID_CODE_LOW = 8'h5A
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Card register port
  input wire spcc_pkg::spcc_bus_req_t bus_req,
  output spcc_pkg::spcc_bus_rsp_t bus_rsp,
  // Pins from the buffered system bus
  input wire logic bus_fault_line,
  input wire logic host_processor_bus_reset,
  // Card processor events
  input wire logic cpu_mem_access,
  input wire logic cpu_misalign_fault,
  // Interrupt vector load from card firmware
  input wire logic vector_load,
  input wire logic [7:0] irq_vector,
  // Cache control
  output logic cache_disable,
  output logic cache_flush_all,
  output logic cache_flush_data,
  // Processor and interrupt control
  output logic local_cpu_irq_request,
  output logic host_irq_request,
  output logic mem_exception,
  output logic cpu_halt,
  output logic card_reset
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  // Bits that hardware may change on its own, besides the addressed one
  localparam logic [15:0] HW_TOUCH = 16'h080B;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [1:0] pin_sync;
  logic bus_fault_s;
  logic host_reset_s;

  spcc_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .async_in({host_processor_bus_reset, bus_fault_line}),
    .sync_out(pin_sync)
  );

  assign bus_fault_s = pin_sync[0];
  assign host_reset_s = pin_sync[1];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [15:0] csr_q;
  logic [15:0] csr_d;
  logic [15:0] id_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic flush_all_q;
  logic flush_data_q;
  logic mem_exc_q;

  wire take = ce && bus_req.sel;
  wire in_csr = (bus_req.addr >= spcc_pkg::CSR_BASE) &&
                (bus_req.addr <= spcc_pkg::CSR_LAST);
  wire in_id = (bus_req.addr == spcc_pkg::ID_ADDR);
  wire [4:0] bit_idx = bus_req.addr[6:2];
  wire csr_wr = take && bus_req.wr && in_csr;
  wire wval = bus_req.wdata[0];
  wire csr_rd = take && !bus_req.wr && in_csr;
  wire id_rd = take && !bus_req.wr && in_id;
  wire hit_flush_all = take && (bus_req.addr == spcc_pkg::FLUSH_ALL_ADDR);
  wire hit_flush_data = take && (bus_req.addr == spcc_pkg::FLUSH_DATA_ADDR);

  // ----------------------------------------------------------------
  // Per-bit write select
  // ----------------------------------------------------------------
  logic [15:0] wr_bit;

  // one address per bit, reserved bits never selected
  for (genvar i = 0; i < 16; i++) begin : g_wsel
    assign wr_bit[i] = csr_wr && (bit_idx == 5'(i)) && spcc_pkg::CSR_IMPL_MASK[i];
  end

  // ----------------------------------------------------------------
  // Hardware events
  // ----------------------------------------------------------------
  // a fault only counts while the card is touching main memory
  wire fault_evt = bus_fault_s && cpu_mem_access;
  logic [15:0] hw_set;
  logic [15:0] hw_clr;

  // misalign, bus error, reset forces halt
  assign hw_set = {4'h0,
                   cpu_misalign_fault,
                   7'h00,
                   fault_evt,
                   1'b0,
                   csr_q[spcc_pkg::BIT_RESET],
                   1'b0};
  // host bus reset drops the card reset bit
  assign hw_clr = {15'h0000, host_reset_s};

  // ----------------------------------------------------------------
  // Control/status next value
  // ----------------------------------------------------------------
  // Hardware sets win over a software clear in the same cycle, so no
  // event is lost; the host reset clear wins over a software set of bit 0
  // because the card must come out of reset with the host bus.
  // merge written bit, events and mask
  assign csr_d = (((csr_q & ~wr_bit) | (wr_bit & {16{wval}}) | hw_set)
                  & ~hw_clr) & spcc_pkg::CSR_IMPL_MASK;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // power-up leaves cache off and processor halted
      csr_q <= spcc_pkg::CSR_RESET;
    end else if (ce) begin
      csr_q <= csr_d;
    end
  end

  // ----------------------------------------------------------------
  // Identification/vector register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      id_q <= {spcc_pkg::ID_HIGH_RESET, ID_CODE_LOW};
    end else if (ce && vector_load) begin
      id_q <= {spcc_pkg::ID_HIGH_RESET, irq_vector};
    end
  end

  // ----------------------------------------------------------------
  // Read data and answer
  // ----------------------------------------------------------------
  // Upper half of the word is left at zero rather than floating
  // 16-bit register widened to a word
  assign rdata_d = csr_rd ? {16'h0000, csr_q} :
                   id_rd ? {16'h0000, id_q} :
                   32'h0000_0000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      ack_q <= bus_req.sel;
      rdata_q <= rdata_d;
    end
  end

  assign bus_rsp = '{ack: ack_q, rdata: rdata_q};

  // ----------------------------------------------------------------
  // Strobes toward cache and processor
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flush_all_q <= 1'b0;
      flush_data_q <= 1'b0;
      mem_exc_q <= 1'b0;
    end else if (ce) begin
      flush_all_q <= hit_flush_all;
      flush_data_q <= hit_flush_data;
      // memory exception on a faulted access
      mem_exc_q <= fault_evt;
    end
  end

  assign cache_flush_all = flush_all_q;
  assign cache_flush_data = flush_data_q;
  assign mem_exception = mem_exc_q;

  // ----------------------------------------------------------------
  // Level outputs from the control/status bits
  // ----------------------------------------------------------------
  // cache off level
  assign cache_disable = csr_q[spcc_pkg::BIT_CACHE_OFF];
  assign local_cpu_irq_request = csr_q[spcc_pkg::BIT_LOCAL_IRQ];
  assign host_irq_request = csr_q[spcc_pkg::BIT_HOST_IRQ];
  // Halt is a clean stall, so the processor resumes where it stopped;
  // the connector inhibit path is outside this block.
  // synchronous halt
  assign cpu_halt = csr_q[spcc_pkg::BIT_HALT];
  assign card_reset = csr_q[spcc_pkg::BIT_RESET];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence halt_set_s;
    ce && wr_bit[spcc_pkg::BIT_HALT] && wval;
  endsequence

  sequence halt_clear_s;
    ce && wr_bit[spcc_pkg::BIT_HALT] && !wval;
  endsequence

  sequence card_reset_s;
    ce && csr_q[spcc_pkg::BIT_RESET];
  endsequence

  a_read_word_shape: assert property (
    csr_rd |=> (bus_rsp.ack && bus_rsp.rdata == {16'h0000, $past(csr_q)}))
    else $error("control read word wrong");

  a_write_one_bit: assert property (
    csr_wr |=> ((csr_q & ~$past(wr_bit) & ~HW_TOUCH) ==
                ($past(csr_q) & ~$past(wr_bit) & ~HW_TOUCH)))
    else $error("write touched other bits");

  a_reserved_zero: assert property (
    ce && csr_wr && wval |=> (csr_q[15] == 1'b0 && csr_q[12] == 1'b0))
    else $error("reserved bit became one");

  a_common_zero: assert property (
    csr_rd |=> (bus_rsp.rdata[10:4] == 7'h00))
    else $error("bits 4 to 10 not zero");

  a_cache_disable: assert property (
    ce && wr_bit[spcc_pkg::BIT_CACHE_OFF] |=> cache_disable == $past(wval))
    else $error("cache disable not written");

  a_flush_pulse: assert property (
    hit_flush_all |=> (cache_flush_all && !cache_flush_data))
    else $error("whole flush missing");

  a_flush_data: assert property (
    hit_flush_data |=> (cache_flush_data && !cache_flush_all))
    else $error("data flush missing");

  a_misalign_set: assert property (
    ce && cpu_misalign_fault |=> csr_q[spcc_pkg::BIT_MISALIGN])
    else $error("misalign flag not set");

  a_fault_except: assert property (
    ce && fault_evt |=> (csr_q[spcc_pkg::BIT_BUS_ERR] && mem_exception))
    else $error("bus fault not flagged");

  a_pin_to_except: assert property (
    ce && $past(ce) && bus_fault_line && cpu_mem_access && $stable(bus_fault_line)
      ##1 ce && cpu_mem_access [*4] |=> mem_exception)
    else $error("pin fault gave no exception");

  a_irq_levels: assert property (
    ce && wr_bit[spcc_pkg::BIT_HOST_IRQ] && wval ##1 !(ce && wr_bit[spcc_pkg::BIT_HOST_IRQ])
      |-> host_irq_request [*2])
    else $error("host interrupt level dropped");

  a_local_irq: assert property (
    ce && wr_bit[spcc_pkg::BIT_LOCAL_IRQ] |=> local_cpu_irq_request == $past(wval))
    else $error("local interrupt not following bit");

  a_reset_halts: assert property (
    card_reset_s |=> cpu_halt)
    else $error("card reset did not halt");

  a_halt_hold: assert property (
    halt_set_s |=> cpu_halt)
    else $error("halt not set by write");

  a_halt_stays: assert property (
    cpu_halt && !(ce && wr_bit[spcc_pkg::BIT_HALT] && !wval) |=> cpu_halt)
    else $error("halt dropped without clear");

  a_host_clear: assert property (
    ce && host_reset_s |=> !card_reset)
    else $error("host reset left card reset");

  a_id_vector: assert property (
    ce && vector_load |=> id_q == {spcc_pkg::ID_HIGH_RESET, $past(irq_vector)})
    else $error("vector not loaded");

  a_id_read: assert property (
    id_rd |=> bus_rsp.rdata == {16'h0000, $past(id_q)})
    else $error("identity read wrong");

  a_halt_resume: assert property (
    halt_clear_s ##0 !card_reset |=> !cpu_halt)
    else $error("halt clear did not resume");

  a_host_irq_clear: assert property (
    ce && wr_bit[spcc_pkg::BIT_HOST_IRQ] && !wval |=> !host_irq_request)
    else $error("host interrupt not cleared");

  a_misalign_clear: assert property (
    ce && wr_bit[spcc_pkg::BIT_MISALIGN] && !wval && !cpu_misalign_fault |=>
      !csr_q[spcc_pkg::BIT_MISALIGN])
    else $error("misalign flag not cleared");

  a_flush_single: assert property (
    ce && !hit_flush_all && !hit_flush_data |=> !cache_flush_all && !cache_flush_data)
    else $error("flush strobe without access");

  a_ack_follows: assert property (
    ce && !bus_req.sel |=> !bus_rsp.ack && bus_rsp.rdata == 32'h0000_0000)
    else $error("answer without request");

  a_vector_hold: assert property (
    ce && !vector_load |=> $stable(id_q))
    else $error("identity changed without load");

  // Enable low must freeze every register, events included
  a_ce_freeze: assert property (
    !ce |=> $stable(csr_q) && $stable(id_q) && $stable(ack_q) && $stable(mem_exc_q))
    else $error("state moved while enable low");

endmodule // spcc_ctrl

// ==== verification/spcc_host_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host side of the buffered system bus: fault and reset pins
// ----------------------------------------------------------------
module spcc_host_model (
  // Requests from the bench
  input wire logic fault_req,
  input wire logic reset_req,
  // Pins toward the card
  output logic bus_fault_line,
  output logic host_processor_bus_reset
);
  // Pins move off the card clock grid, as a foreign bus would drive them
  initial begin
    bus_fault_line = 1'b0;
    host_processor_bus_reset = 1'b0;
  end
  always @(fault_req) bus_fault_line <= #7 fault_req;
  always @(reset_req) host_processor_bus_reset <= #7 reset_req;
endmodule // spcc_host_model

// ==== verification/tb_secondary_processor_card_control.sv ====
`timescale 1ns/1ns
module tb_secondary_processor_card_control;
  // Arbitrary identity low byte
  localparam logic [7:0] ID_LOW = 8'h3C;
  logic clk, reset_n, ce, fault_req, reset_req, bus_fault_line, host_processor_bus_reset;
  spcc_pkg::spcc_bus_req_t bus_req;
  spcc_pkg::spcc_bus_rsp_t bus_rsp;
  logic cpu_mem_access, cpu_misalign_fault, vector_load, fa, fd;
  logic [7:0] irq_vector;
  logic cache_disable, cache_flush_all, cache_flush_data, local_cpu_irq_request;
  logic host_irq_request, mem_exception, cpu_halt, card_reset;
  logic [31:0] rd;
  logic [15:0] exp_csr;
  int failures, checks_done;

  spcc_host_model host_u (.fault_req(fault_req), .reset_req(reset_req),
    .bus_fault_line(bus_fault_line), .host_processor_bus_reset(host_processor_bus_reset));

  spcc_ctrl #(.ID_CODE_LOW(ID_LOW)) dut_u (.clk(clk), .reset_n(reset_n), .ce(ce),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .bus_fault_line(bus_fault_line),
    .host_processor_bus_reset(host_processor_bus_reset), .cpu_mem_access(cpu_mem_access),
    .cpu_misalign_fault(cpu_misalign_fault), .vector_load(vector_load),
    .irq_vector(irq_vector), .cache_disable(cache_disable),
    .cache_flush_all(cache_flush_all), .cache_flush_data(cache_flush_data),
    .local_cpu_irq_request(local_cpu_irq_request), .host_irq_request(host_irq_request),
    .mem_exception(mem_exception), .cpu_halt(cpu_halt), .card_reset(card_reset));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Entered and left just after a rising edge; sel drops before the next request
  task automatic access(input logic wr, input logic [31:0] addr, input logic wv);
    bus_req = '{sel: 1'b1, wr: wr, addr: addr, wdata: {31'h0, wv}};
    @(posedge clk);
    #2;
    chk({31'h0, bus_rsp.ack}, 32'h1);
    rd = bus_rsp.rdata;
    fa = cache_flush_all;
    fd = cache_flush_data;
    bus_req.sel = 1'b0;
    @(posedge clk);
    #2;
  endtask

  task automatic wr_bit(input int b, input logic v);
    access(1'b1, spcc_pkg::CSR_BASE + 32'(4 * b), v);
  endtask

  task automatic outs(input logic [7:0] e);
    chk({24'h0, cache_disable, local_cpu_irq_request, host_irq_request, cpu_halt, card_reset,
      mem_exception, cache_flush_all, cache_flush_data}, {24'h0, e});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    checks_done = 0;
    reset_n = 1'b0;
    ce = 1'b1;
    fault_req = 1'b0;
    reset_req = 1'b0;
    bus_req = '0;
    cpu_mem_access = 1'b0;
    cpu_misalign_fault = 1'b0;
    vector_load = 1'b0;
    irq_vector = 8'h00;
    idle(10);
    reset_n = 1'b1;
    access(1'b0, spcc_pkg::CSR_BASE, 1'b0);
    chk(rd, 32'h0000_4002);
    outs(8'h90);
    access(1'b0, spcc_pkg::ID_ADDR, 1'b0);
    chk(rd, {24'h0, ID_LOW});
    exp_csr = 16'h4002;
    // Set then clear bits 2 to 15 except flags 3 and 11, reserved ones included
    for (int v = 1; v >= 0; v--) begin
      for (int b = 2; b < 16; b++) begin
        if (b != 3 && b != 11) begin
          wr_bit(b, v[0]);
          exp_csr[b] = v[0] & spcc_pkg::CSR_IMPL_MASK[b];
          access(1'b0, spcc_pkg::CSR_BASE + 32'(4 * b), 1'b0);
          chk(rd, {16'h0, exp_csr});
        end
      end
      outs(v[0] ? 8'hF0 : 8'h10);
    end
    wr_bit(1, 1'b0);
    outs(8'h00);
    wr_bit(1, 1'b1);
    outs(8'h10);
    wr_bit(1, 1'b0);
    access(1'b0, spcc_pkg::FLUSH_ALL_ADDR, 1'b0);
    chk({30'h0, fa, fd}, 32'h2);
    access(1'b1, spcc_pkg::FLUSH_DATA_ADDR, 1'b0);
    chk({30'h0, fa, fd}, 32'h1);
    cpu_misalign_fault = 1'b1;
    idle(1);
    cpu_misalign_fault = 1'b0;
    access(1'b0, spcc_pkg::CSR_BASE, 1'b0);
    chk(rd, 32'h0000_0800);
    wr_bit(11, 1'b0);
    access(1'b0, spcc_pkg::CSR_BASE, 1'b0);
    chk(rd, 32'h0);
    // Enable low freezes the flags even while a fault event is offered
    ce = 1'b0;
    cpu_misalign_fault = 1'b1;
    idle(2);
    cpu_misalign_fault = 1'b0;
    ce = 1'b1;
    access(1'b0, spcc_pkg::CSR_BASE, 1'b0);
    chk(rd, 32'h0);
    // A fault with no memory access in progress must leave the card alone
    fault_req = 1'b1;
    idle(8);
    outs(8'h00);
    cpu_mem_access = 1'b1;
    idle(8);
    outs(8'h04);
    fault_req = 1'b0;
    cpu_mem_access = 1'b0;
    idle(8);
    access(1'b0, spcc_pkg::CSR_BASE, 1'b0);
    chk(rd, 32'h0000_0008);
    wr_bit(3, 1'b0);
    wr_bit(0, 1'b1);
    idle(1);
    outs(8'h18);
    reset_req = 1'b1;
    idle(8);
    reset_req = 1'b0;
    idle(8);
    outs(8'h10);
    wr_bit(1, 1'b0);
    access(1'b0, spcc_pkg::CSR_BASE, 1'b0);
    chk(rd, 32'h0);
    access(1'b0, 32'h0001_004C, 1'b0);
    chk(rd, 32'h0);
    access(1'b0, 32'h0002_0000, 1'b0);
    chk(rd, 32'h0);
    access(1'b1, spcc_pkg::ID_ADDR, 1'b1);
    access(1'b0, spcc_pkg::ID_ADDR, 1'b0);
    chk(rd, {24'h0, ID_LOW});
    irq_vector = 8'hA7;
    vector_load = 1'b1;
    idle(1);
    vector_load = 1'b0;
    access(1'b0, spcc_pkg::ID_ADDR, 1'b0);
    chk(rd, 32'h0000_00A7);
    end_sim();
  end

  // Whole sequence needs well under 300 cycles
  initial begin
    #100000;
    failures++;
    end_sim();
  end
endmodule // tb_secondary_processor_card_control
